/* File: factory_restore_detector.v */
// Factory restore detector: watches the restore switch after reset release.
// Assumes the pins arrive asynchronously; clk runs at 200 MHz.
`timescale 1ns/100ps
`include "restore_consts.vh"
module factory_restore_detector #(
   parameter [31:0] WINDOW_CYC   = `WINDOW_CYCLES,
   parameter [31:0] HOLD_CYC     = `HOLD_MIN_CYCLES,
   parameter [11:0] DEBOUNCE_CYC = `DEBOUNCE_CYCLES
) (
   input  wire clk,
   input  wire reset,
   input  wire external_reset_n,
   input  wire restore_switch_n,
   input  wire restore_switch_connected,
   output reg  reset_led_red,
   output reg  restore_config,
   output reg  clear_acl,
   output reg  clear_logs,
   output reg  clear_mote_list,
   output reg  restore_done
);
   localparam [1:0] ST_RESET  = 2'd0;
   localparam [1:0] ST_WINDOW = 2'd1;
   localparam [1:0] ST_HOLD   = 2'd2;
   localparam [1:0] ST_IDLE   = 2'd3;

   reg        ext_s1;
   reg        ext_s2;
   reg        ext_s3;
   reg        ext_level_n;
   reg  [1:0] state;
   reg  [1:0] next_state;
   reg [31:0] window_count;
   reg [31:0] hold_count;
   wire       switch_n;
   wire       request_n;
   wire       window_end;
   wire       hold_met;
   wire       fire;

   ////////////////////////////////////////////////////////////////////////
   // An open pin reads high, so it never counts as a request.
   assign switch_n = restore_switch_connected ? restore_switch_n
                                              : 1'b1;

   restore_debounce #(
      .STABLE_CYCLES (DEBOUNCE_CYC)
   ) u_debounce (
      .clk     (clk),
      .reset   (reset),
      .pin_n   (switch_n),
      .level_n (request_n)
   );

   ////////////////////////////////////////////////////////////////////////
   // External reset: three stages, change taken when the last two agree.
   always @(posedge clk) begin
      if (reset) begin
         ext_s1      <= 1'b0;
         ext_s2      <= 1'b0;
         ext_s3      <= 1'b0;
         ext_level_n <= 1'b0;
      end else begin
         ext_s1 <= external_reset_n;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
         if (ext_s2 == ext_s3) begin
            ext_level_n <= ext_s3;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // The window closes on its last counted cycle. The count saturates
   // one past that, at WINDOW_CYC, so a late press can never reopen it.
   assign window_end = (window_count >= WINDOW_CYC - 32'd1);

   // The hold is complete on the cycle its count reaches the minimum.
   assign hold_met = (hold_count >= HOLD_CYC - 32'd1);

   // Hold time of 1 s is met well inside the 20 s limit: restore fires
   // on the cycle the hold count completes. A restore that would fall in
   // the cycle the external reset returns is dropped, since the device
   // is already going back into reset.
   assign fire = (state == ST_HOLD) && !request_n && hold_met
                 && ext_level_n;

   ////////////////////////////////////////////////////////////////////////
   // Sequencing: reset, acceptance window, hold, and a final idle state
   // that only a new external reset leaves.
   always @* begin
      next_state = state;
      case (state)
         ST_RESET: begin
            if (ext_level_n) begin
               next_state = ST_WINDOW;
            end
         end
         ST_WINDOW: begin
            // Only a press that is down while the window is still open is honoured.
            if (window_end) begin
               next_state = ST_IDLE;
            end else if (!request_n) begin
               next_state = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (fire) begin
               next_state = ST_IDLE;
            end else if (request_n) begin
               // A release before the hold ends may retry while the
               // window is still open.
               if (window_end) begin
                  next_state = ST_IDLE;
               end else begin
                  next_state = ST_WINDOW;
               end
            end
         end
         ST_IDLE: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_RESET;
         end
      endcase
      if (!ext_level_n) begin
         next_state = ST_RESET;
      end
   end

   always @(posedge clk) begin
      if (reset) begin
         state <= ST_RESET;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Window counter: starts from zero at each release of the external
   // reset and stops at the window length rather than wrapping.
   always @(posedge clk) begin
      if (reset) begin
         window_count <= 32'h00000000;
      end else if (state == ST_RESET) begin
         window_count <= 32'h00000000;
      end else if (window_count < WINDOW_CYC) begin
         window_count <= window_count + 32'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Hold counter: counts only while the request stays down in the hold
   // state, so any release starts the hold over.
   always @(posedge clk) begin
      if (reset) begin
         hold_count <= 32'h00000000;
      end else if (state == ST_HOLD && !request_n) begin
         hold_count <= hold_count + 32'd1;
      end else begin
         hold_count <= 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // The indicator follows the synchronised reset pin, so it lags the
   // pin by a few cycles; far below anything the eye can see.
   always @(posedge clk) begin
      if (reset) begin
         reset_led_red <= 1'b1;
      end else begin
         reset_led_red <= !ext_level_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs are one-cycle strobes to the storage logic, all in the same
   // cycle so that no store is left half restored.
   always @(posedge clk) begin
      if (reset) begin
         restore_config  <= 1'b0;
         clear_acl       <= 1'b0;
         clear_logs      <= 1'b0;
         clear_mote_list <= 1'b0;
      end else begin
         restore_config  <= fire;
         clear_acl       <= fire;
         clear_logs      <= fire;
         clear_mote_list <= fire;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // The done flag marks that this release has had its restore; only a
   // new external reset clears it.
   always @(posedge clk) begin
      if (reset) begin
         restore_done <= 1'b0;
      end else if (!ext_level_n) begin
         restore_done <= 1'b0;
      end else if (fire) begin
         restore_done <= 1'b1;
      end
   end
endmodule // factory_restore_detector

/* File: restore_consts.vh */
// Constants for the factory restore detector.
// Assumes a 200 MHz clock; window and hold counts are derived from times in milliseconds.
`ifndef RESTORE_CONSTS_VH
`define RESTORE_CONSTS_VH
`define CLK_PERIOD_NS      5
`define CYCLES_PER_MS      (1000000 / `CLK_PERIOD_NS)
`define WINDOW_MS          3000
`define WINDOW_CYCLES      (`WINDOW_MS * `CYCLES_PER_MS)
`define HOLD_MIN_MS        1000
`define HOLD_MIN_CYCLES    (`HOLD_MIN_MS * `CYCLES_PER_MS)
`define HOLD_MAX_MS        20000
`define DEBOUNCE_US        10
// Ten microseconds at 5 ns a cycle, sized for the debouncer's counter.
`define DEBOUNCE_CYCLES    12'd2000
`define CNT_W              32
`define DB_W               12
`endif

/* File: restore_debounce.v */
// Debouncer for the restore switch pin.
// Assumes an asynchronous, active-low pin that may bounce.
`timescale 1ns/100ps
module restore_debounce #(
   parameter [11:0] STABLE_CYCLES = 12'd2000
) (
   input  wire clk,
   input  wire reset,
   input  wire pin_n,
   output reg  level_n
);
   reg        sync1;
   reg        sync2;
   reg        sync3;
   reg [11:0] stable_count;

   // Reset to high keeps an idle pin inactive.
   always @(posedge clk) begin
      if (reset) begin
         sync1        <= 1'b1;
         sync2        <= 1'b1;
         sync3        <= 1'b1;
         stable_count <= 12'h000;
         level_n      <= 1'b1;
      end else begin
         sync1 <= pin_n;
         sync2 <= sync1;
         sync3 <= sync2;
         // A bounce restarts the count, so one press gives one edge.
         if (sync2 != sync3 || sync3 == level_n) begin
            stable_count <= 12'h000;
         end else if (stable_count >= STABLE_CYCLES - 12'd1) begin
            level_n      <= sync3;
            stable_count <= 12'h000;
         end else begin
            stable_count <= stable_count + 12'd1;
         end
      end
   end
endmodule // restore_debounce

/* File: factory_restore_detector_assertions.sv */
// Port checker for the factory restore detector.
// Assumes clk at 200 MHz and a synchronous active-high reset.
`timescale 1ns/100ps
module factory_restore_detector_assertions (
   input wire clk,
   input wire reset,
   input wire external_reset_n,
   input wire restore_switch_n,
   input wire restore_switch_connected,
   input wire reset_led_red,
   input wire restore_config,
   input wire clear_acl,
   input wire clear_logs,
   input wire clear_mote_list,
   input wire restore_done
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_strobes_together: assert property (
      restore_config |-> clear_acl && clear_logs && clear_mote_list)
      else $error("strobes apart");
   a_acl_with_config: assert property (
      clear_acl |-> restore_config)
      else $error("acl clear alone");
   a_done_on_strobe: assert property (
      $rose(restore_done) |-> restore_config)
      else $error("done without strobe");
   a_single_restore: assert property (
      restore_done && $past(restore_done) |-> !restore_config)
      else $error("second restore");
   a_strobe_one_cycle: assert property (
      restore_config |=> !restore_config)
      else $error("strobe too long");
   a_no_restore_held: assert property (
      !external_reset_n [*8] |-> !restore_config)
      else $error("restore in reset");
   a_led_lit_held: assert property (
      !external_reset_n [*8] |-> reset_led_red)
      else $error("led dark in reset");
   a_led_dark_run: assert property (
      external_reset_n [*8] |-> !reset_led_red)
      else $error("led lit in run");
endmodule // factory_restore_detector_assertions
bind factory_restore_detector factory_restore_detector_assertions chk (
   .clk(clk), .reset(reset), .external_reset_n(external_reset_n),
   .restore_switch_n(restore_switch_n),
   .restore_switch_connected(restore_switch_connected),
   .reset_led_red(reset_led_red), .restore_config(restore_config),
   .clear_acl(clear_acl), .clear_logs(clear_logs),
   .clear_mote_list(clear_mote_list), .restore_done(restore_done));

/* File: restore_button.sv */
// Push button model for the restore switch pin.
// Assumes the pin is pulled high while the button is open.
`timescale 1ns/100ps
module restore_button (
   input  wire clk,
   input  wire press,
   output reg  switch_n = 1'b1
);
   reg       last   = 1'b0;
   reg [3:0] bounce = 4'h0;
   // Contacts chatter for a few cycles after every change of the press.
   always @(posedge clk) begin
      if (press != last) bounce <= 4'h8;
      else if (bounce != 4'h0) bounce <= bounce - 4'h1;
      last <= press;
      switch_n <= (bounce != 4'h0) ? ~switch_n : ~press;
   end
endmodule // restore_button

/* File: factory_restore_detector_test.sv */
// Testbench for the factory restore detector.
// Assumes short window and hold counts given to the instance so whole
// restores fit in the run; the debounce span keeps its real length.
`timescale 1ns/100ps
module factory_restore_detector_test;
   localparam [31:0] WINDOW = 32'd10000;
   localparam [31:0] HOLD   = 32'd5000;
   logic clk = 1'b0, reset = 1'b1, ext_n = 1'b0, press = 1'b0, conn = 1'b1;
   wire  sw_n, led, cfg, acl, logs, motes, done;
   int   fails = 0, comparisons = 0, strobes = 0;
   int   acl_strobes = 0, log_strobes = 0, mote_strobes = 0;
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      if (cfg === 1'b1) strobes++;
      if (acl === 1'b1) acl_strobes++;
      if (logs === 1'b1) log_strobes++;
      if (motes === 1'b1) mote_strobes++;
   end
   restore_button btn (.clk(clk), .press(press), .switch_n(sw_n));
   factory_restore_detector #(.WINDOW_CYC(WINDOW), .HOLD_CYC(HOLD),
      .DEBOUNCE_CYC(12'd2000)) uut (.clk(clk), .reset(reset),
      .external_reset_n(ext_n), .restore_switch_n(sw_n),
      .restore_switch_connected(conn), .reset_led_red(led),
      .restore_config(cfg), .clear_acl(acl), .clear_logs(logs),
      .clear_mote_list(motes), .restore_done(done));
   task check(input string name, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task t_led;
      ext_n = 1'b0;
      cyc(10);
      check("led held", led, 1);
      check("done held", done, 0);
      ext_n = 1'b1;
      cyc(10);
      check("led run", led, 0);
      $display("test led done");
   endtask
   // A press of 15 us passes the debouncer but falls far short of the hold.
   task t_press(input logic c, input logic e);
      conn = c;
      ext_n = e;
      press = 1'b1;
      cyc(3000);
      press = 1'b0;
      cyc(2100);
      $display("test press done");
   endtask
   // A press held past the hold span in a fresh window restores once;
   // holding it until the window has closed starts no second restore.
   task t_restore;
      conn = 1'b1;
      ext_n = 1'b1;
      cyc(20);
      press = 1'b1;
      cyc(HOLD);
      check("hold too short", strobes, 0);
      cyc(2100);
      check("restore", strobes, 1);
      check("acl cleared", acl_strobes, 1);
      check("logs cleared", log_strobes, 1);
      check("motes cleared", mote_strobes, 1);
      check("restore done", done, 1);
      cyc(WINDOW);
      check("one restore", strobes, 1);
      press = 1'b0;
      cyc(2100);
      $display("test restore done");
   endtask
   // A second reset mid-run clears the done flag and opens a new window;
   // a press that starts after that window has closed is ignored.
   task t_late;
      ext_n = 1'b0;
      cyc(10);
      check("done cleared", done, 0);
      check("led relit", led, 1);
      ext_n = 1'b1;
      cyc(WINDOW + 100);
      press = 1'b1;
      cyc(HOLD + 2200);
      check("late press", strobes, 1);
      check("late done", done, 0);
      press = 1'b0;
      cyc(2100);
      $display("test late done");
   endtask
   task tally_and_finish;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      // About 55k cycles are planned; this allows some 80k.
      #400000;
      fails++;
      tally_and_finish;
   end
   initial begin
      cyc(3);
      reset = 1'b0;
      t_led;
      t_press(1'b1, 1'b1);
      check("short press", strobes, 0);
      check("short press done", done, 0);
      t_press(1'b0, 1'b1);
      check("unwired pin", strobes, 0);
      t_press(1'b1, 1'b0);
      check("press in reset", strobes, 0);
      t_restore;
      t_late;
      tally_and_finish;
   end
endmodule // factory_restore_detector_test
